//--- logic/acr_device.sv
// Purpose: Device end: conversion timing and serial result readout
// Assumes: Result word supplied by a sampled digital input
// Notes:   Link pins sampled through two flops before use
//
// Operation
// - Host clock at most 2.1MHz, 200ns phases; the host here runs 2.5MHz (two 5-cycle phases)
// - Host keeps clock low during conversion
// - Select falling freezes sample, drives data low
// - Conversion internally timed, result into shifter
// - Data output high marks conversion end
// - Data changes on clock falling, MSB first
// - Frame: leading one, ten bits, two sub-bits
// - Extra clocks give zeros, no disturbance
// - Host waits data rising or 7.5us
// - Host gives 11 clocks before deselect
// - Shortest cycle: 10.5 clocks at full rate
// - Host samples data on clock rising; the host here samples at the end of the high phase, just before the fall
// - Host holds select high minimum time
// - Early deselect aborts; host waits acquisition
// - Standard master uses polarity 0, phase 0
// - Two bytes: one plus seven, three+two+zeros
// - Straight binary result, 1024 steps
// - Queued master clock at most 2.097MHz
// - Host masters clock, select from GPIO
// - Shutdown input low stops the device
`timescale 1ns/1ps
module acr_device
   import acr_pkg::*;
#(
   parameter int CONV_CYC = CONV_DEV_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   acr_link_if.dev                     link,
   input  wire logic                   shutdown_n,
   input  wire logic [RESULT_BITS-1:0] sample_in,
   input  wire logic [SUB_BITS-1:0]    sub_in,
   output logic                        converting,
   output logic                        shut_down
);
   typedef enum {D_IDLE, D_CONV, D_READ} acr_dst_t;
   acr_dst_t              st_reg;
   logic [CNT_W-1:0]      cnt_reg;
   logic [FRAME_BITS-1:0] sh_reg;
   logic [RESULT_BITS-1:0] hold_reg;
   logic [SUB_BITS-1:0]   hsub_reg;
   logic                  cs1_reg, cs2_reg, cs3_reg;
   logic                  ck1_reg, ck2_reg, ck3_reg;
   logic                  sd1_reg, sd2_reg;
   logic                  cs_fall, cs_rise, ck_fall;

   always_ff @(posedge clk) begin
      if (rst) begin
         cs1_reg <= 1'b1;
         cs2_reg <= 1'b1;
         cs3_reg <= 1'b1;
         ck1_reg <= 1'b0;
         ck2_reg <= 1'b0;
         ck3_reg <= 1'b0;
         sd1_reg <= 1'b1;
         sd2_reg <= 1'b1;
      end else begin
         cs1_reg <= link.cs_n;
         cs2_reg <= cs1_reg;
         cs3_reg <= cs2_reg;
         ck1_reg <= link.sclk;
         ck2_reg <= ck1_reg;
         ck3_reg <= ck2_reg;
         sd1_reg <= shutdown_n;
         sd2_reg <= sd1_reg;
      end
   end

   assign cs_fall = !cs2_reg && cs3_reg;
   assign cs_rise = cs2_reg && !cs3_reg;
   assign ck_fall = !ck2_reg && ck3_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg  <= D_IDLE;
         cnt_reg <= '0;
      end else if (!sd2_reg) begin
         st_reg  <= D_IDLE;
      end else begin
         unique case (st_reg)
            D_IDLE: if (cs_fall) begin
               st_reg  <= D_CONV;
               cnt_reg <= '0;
            end
            D_CONV: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cs_rise) begin
                  st_reg <= D_IDLE;
               end else if (cnt_reg == CNT_W'(CONV_CYC - 1)) begin
                  st_reg <= D_READ;
               end
            end
            D_READ: if (cs_rise) begin
               st_reg <= D_IDLE;
            end
         endcase
      end
   end

   // Freeze sample at select falling
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_reg <= RESULT_RST;
         hsub_reg <= '0;
      end else if (st_reg == D_IDLE && cs_fall) begin
         hold_reg <= sample_in;
         hsub_reg <= sub_in;
      end
   end

   // Top bit drives the pin; zeros shift in behind the frame
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_reg <= '0;
      end else if (st_reg == D_CONV && cnt_reg == CNT_W'(CONV_CYC - 1)) begin
         sh_reg <= {1'b1, hold_reg, hsub_reg};
      end else if (st_reg == D_READ && ck_fall) begin
         sh_reg <= {sh_reg[FRAME_BITS-2:0], 1'b0};
      end else if (st_reg != D_READ) begin
         sh_reg <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         link.dout_o  <= 1'b0;
         link.dout_oe <= 1'b0;
      end else begin
         link.dout_o  <= sh_reg[FRAME_BITS-1];
         link.dout_oe <= st_reg != D_IDLE;
      end
   end

   assign converting = st_reg == D_CONV;
   assign shut_down  = !sd2_reg;
endmodule : acr_device

//--- logic/acr_fifo.sv
// Purpose: Result buffer between host shifter and user side
// Assumes: Single clock
// Notes:   Depth a power of two
`timescale 1ns/1ps
module acr_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   logic             full;
   logic             empty;
   assign full      = (wr_reg[AW] != rd_reg[AW]) &&
                      (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign empty     = wr_reg == rd_reg;
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
      end else if (in_valid && !full) begin
         wr_reg <= wr_reg + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_reg <= '0;
      end else if (out_ready && !empty) begin
         rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule : acr_fifo

//--- logic/acr_host.sv
// Purpose: Host end: starts conversions and reads results
// Assumes: Mode 0 framing, host makes the clock by division
// Notes:   Results go into a FIFO; full FIFO stalls the next start
`timescale 1ns/1ps
module acr_host
   import acr_pkg::*;
#(
   parameter int HALF_CYC = SCLK_PHASE_CYC,
   parameter int EDGES    = READ_EDGES
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   acr_link_if.host                  link,
   input  wire logic                 start,
   output logic                      busy,
   output logic [FRAME_BITS-2:0]     res_data,
   output logic                      res_valid,
   input  wire logic                 res_ready
);
   typedef enum {H_IDLE, H_CONV, H_LOW, H_HIGH, H_GAP} acr_hst_t;
   acr_hst_t           st_reg;
   logic [CNT_W-1:0]   cnt_reg;
   logic [4:0]         edge_reg;
   logic [FRAME_BITS-2:0] sh_reg;
   logic               d1_reg, d2_reg, d3_reg;
   logic               f_ready;
   logic               f_push;

   always_ff @(posedge clk) begin
      if (rst) begin
         // Idle level of the released wire: no false rise after reset
         d1_reg <= 1'b1;
         d2_reg <= 1'b1;
         d3_reg <= 1'b1;
      end else begin
         d1_reg <= link.dout;
         d2_reg <= d1_reg;
         d3_reg <= d2_reg;
      end
   end

   // Sequence: select, wait for data rising or timeout, clock out
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg   <= H_IDLE;
         cnt_reg  <= '0;
         edge_reg <= '0;
      end else begin
         unique case (st_reg)
            H_IDLE: if (start && f_ready) begin
               st_reg  <= H_CONV;
               cnt_reg <= '0;
            end
            H_CONV: begin
               cnt_reg <= cnt_reg + 1'b1;
               if ((d2_reg && !d3_reg) ||
                   cnt_reg == CNT_W'(CONV_MAX_CYC)) begin
                  st_reg   <= H_HIGH;
                  cnt_reg  <= '0;
                  edge_reg <= '0;
               end
            end
            H_HIGH: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CNT_W'(HALF_CYC - 1)) begin
                  cnt_reg  <= '0;
                  edge_reg <= edge_reg + 1'b1;
                  // Leading low phase plus EDGES full clocks
                  st_reg   <= (edge_reg == 5'(EDGES)) ? H_GAP : H_LOW;
               end
            end
            H_LOW: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CNT_W'(HALF_CYC - 1)) begin
                  cnt_reg <= '0;
                  st_reg  <= H_HIGH;
               end
            end
            H_GAP: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CNT_W'(ACQ_MIN_CYC)) begin
                  st_reg <= H_IDLE;
               end
            end
         endcase
      end
   end

   // Clock high for H_LOW phases, rising one cycle after entry: mode 0
   always_ff @(posedge clk) begin
      if (rst) begin
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
      end else begin
         link.sclk <= (st_reg == H_LOW);
         link.cs_n <= !(st_reg == H_CONV || st_reg == H_HIGH ||
                        st_reg == H_LOW);
      end
   end

   // Sample at end of high phase, just before clock falls, after device update settled
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_reg <= '0;
      end else if (st_reg == H_LOW && cnt_reg == CNT_W'(HALF_CYC - 1)) begin
         sh_reg <= {sh_reg[FRAME_BITS-3:0], d2_reg};
      end else if (st_reg == H_IDLE) begin
         // Unused top bit reads zero, not a stale sample
         sh_reg <= '0;
      end
   end

   assign f_push = st_reg == H_GAP && cnt_reg == '0;
   assign busy   = st_reg != H_IDLE;

   acr_fifo #(.WIDTH(FRAME_BITS - 1), .DEPTH(32)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (sh_reg),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .out_data  (res_data),
      .out_valid (res_valid),
      .out_ready (res_ready)
   );
endmodule : acr_host

//--- logic/acr_link_if.sv
// Purpose: Three-wire link between host and converter
// Assumes: Host drives select and clock; device drives data
// Notes:   Released data wire reads high, as a weak pull-up would
`timescale 1ns/1ps
interface acr_link_if;
   logic cs_n;
   logic sclk;
   logic dout_o;
   logic dout_oe;
   logic dout;
   assign dout = dout_oe ? dout_o : 1'b1;
   modport dev  (input cs_n, input sclk, output dout_o, output dout_oe);
   modport host (output cs_n, output sclk, input dout);
endinterface : acr_link_if

//--- logic/acr_pkg.sv
// Purpose: Shared constants and types for the converter readout link
// Assumes: 25 MHz system clock at both ends
// Notes:   Times are in ns; cycle counts derive from them
package acr_pkg;
   localparam int CLK_PERIOD_NS      = 40;
   localparam int RESULT_BITS        = 10;
   localparam int SUB_BITS           = 2;
   localparam int FRAME_BITS         = 1 + RESULT_BITS + SUB_BITS;
   localparam int SCLK_PHASE_MIN_NS  = 200;
   localparam int SCLK_PHASE_CYC     =
      (SCLK_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_NS        = 7500;
   localparam int CONV_MAX_CYC       = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int CONV_DEV_CYC       = CONV_MAX_CYC / 2;
   localparam int SELECT_HIGH_MIN_NS = 500;
   localparam int SELECT_HIGH_MIN_CYC =
      (SELECT_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_MIN_NS         = 1500;
   localparam int ACQ_MIN_CYC        =
      (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_EDGES         = 11;
   localparam int CNT_W              = 9;
   localparam logic [RESULT_BITS-1:0] RESULT_RST = 10'h000;
endpackage : acr_pkg

//--- verification/acr_bench.sv
// Purpose: Bench joining host and converter ends over the link
// Assumes: Conversion shortened to 10 cycles
// Notes:   Checker watches the link beside both ends
`timescale 1ns/1ps
module acr_bench
   import acr_pkg::*;
   ;
   typedef struct {
      logic [RESULT_BITS-1:0] smp;
      logic [SUB_BITS-1:0]    sub;
      logic [10:0]            exp;
   } acr_row_t;
   logic                   clk, rst, start, busy, res_valid, res_ready;
   logic                   shutdown_n, converting, shut_down;
   logic [FRAME_BITS-2:0]  res_data;
   logic [RESULT_BITS-1:0] sample_in;
   logic [SUB_BITS-1:0]    sub_in;
   int                     err_count, compares, count;
   acr_row_t               rows [6];
   acr_link_if link ();
   acr_host i_acr_host (.clk, .rst, .link, .start, .busy, .res_data,
      .res_valid, .res_ready);
   acr_device #(.CONV_CYC(10)) i_acr_device (.clk, .rst, .link,
      .shutdown_n, .sample_in, .sub_in, .converting, .shut_down);
   acr_props i_acr_props (.clk, .rst, .cs_n(link.cs_n),
      .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe(link.dout_oe));
   task automatic end_of_test;
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: flag %b not %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic pop;
      @(posedge clk);
      res_ready <= 1'b1;
      @(posedge clk);
      res_ready <= 1'b0;
      @(negedge clk);
   endtask : pop
   // Hold start until the host pulls select low
   task automatic begin_conv;
      int n;
      @(posedge clk);
      start <= 1'b1;
      n = 0;
      while (link.cs_n !== 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk_bit(link.cs_n, 1'b0);
      @(posedge clk);
      start <= 1'b0;
   endtask : begin_conv
   task automatic convert(input acr_row_t r);
      int n;
      sample_in <= r.smp;
      sub_in    <= r.sub;
      begin_conv();
      repeat (6) @(negedge clk);
      chk_bit(converting, 1'b1);
      n = 0;
      while (res_valid !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk_word(res_data, {1'b0, r.exp});
      pop();
   endtask : convert
   task automatic count_falls(input int cyc, input int stop);
      logic q;
      q = link.cs_n;
      for (int n = 0; n < cyc && count < stop; n++) begin
         @(negedge clk);
         if (link.cs_n === 1'b0 && q === 1'b1) count++;
         q = link.cs_n;
      end
   endtask : count_falls
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   initial begin
      rows = '{'{10'h000, 2'h0, 11'h400}, '{10'h3FF, 2'h3, 11'h7FF},
               '{10'h2AA, 2'h1, 11'h6AA}, '{10'h155, 2'h2, 11'h555},
               '{10'h201, 2'h3, 11'h601}, '{10'h1FE, 2'h0, 11'h5FE}};
      rst = 1'b1;
      start = 1'b0;
      res_ready = 1'b0;
      shutdown_n = 1'b1;
      sample_in = 10'h000;
      sub_in = 2'h0;
      err_count = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         convert(rows[i]);
      end
      @(posedge clk);
      shutdown_n <= 1'b0;
      repeat (5) @(negedge clk);
      chk_bit(shut_down, 1'b1);
      chk_bit(converting, 1'b0);
      @(posedge clk);
      shutdown_n <= 1'b1;
      repeat (5) @(negedge clk);
      chk_bit(shut_down, 1'b0);
      // Reset in mid readout, then a clean conversion
      begin_conv();
      repeat (30) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(negedge clk);
      chk_bit(link.dout_oe, 1'b0);
      chk_bit(link.cs_n, 1'b1);
      chk_bit(res_valid, 1'b0);
      @(posedge clk);
      rst <= 1'b0;
      convert(rows[2]);
      // Fill the buffer with reads stalled, then drain it
      count = 0;
      sample_in <= 10'h0F0;
      @(posedge clk);
      start <= 1'b1;
      count_falls(8000, 32);
      count_falls(400, 99);
      chk_word(12'(count), 12'h020);
      @(posedge clk);
      start <= 1'b0;
      count = 0;
      while (res_valid === 1'b1 && count < 40) begin
         chk_word(res_data, 12'h04F0);
         count++;
         pop();
      end
      chk_word(12'(count), 12'h020);
      end_of_test();
   end
endmodule : acr_bench

//--- verification/acr_props.sv
// Purpose: Link checks between host and converter ends
// Assumes: One clock, synchronous reset
// Notes:   Sees only the link signals
`timescale 1ns/1ps
module acr_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic       oe_q_reg;
   logic       sclk_q_reg;
   logic       conv_reg;
   logic [4:0] fall_cnt_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk) begin
      oe_q_reg   <= dout_oe;
      sclk_q_reg <= sclk;
   end
   // Converting: data driven, end marker not yet seen
   always_ff @(posedge clk) begin
      if (rst || cs_n || dout_o) begin
         conv_reg <= 1'b0;
      end else if (dout_oe && !oe_q_reg) begin
         conv_reg <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || cs_n) begin
         fall_cnt_reg <= 5'h00;
      end else if (sclk_q_reg && !sclk && fall_cnt_reg != 5'h1F) begin
         fall_cnt_reg <= fall_cnt_reg + 5'h01;
      end
   end
   a_oe_on_select:
      assert property ($fell(cs_n) |-> !dout_oe ##[1:8] dout_oe)
      else $error("data not driven after select");
   a_start_low:
      assert property ($rose(dout_oe) |-> !dout_o)
      else $error("data not low at start");
   a_quiet_conv:
      assert property (conv_reg |-> !sclk)
      else $error("clock ran during conversion");
   a_eoc_bound:
      assert property ($rose(dout_oe) |-> ##[1:40] dout_o)
      else $error("no end of conversion");
   a_lead_held:
      assert property ($rose(dout_o) && conv_reg |-> dout_o[*6])
      else $error("leading one not held");
   a_change_on_fall:
      assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
                       |-> !sclk)
      else $error("data changed with clock high");
   a_clk_phase:
      assert property ($rose(sclk) |-> sclk[*5])
      else $error("clock high phase short");
   a_read_edges:
      assert property ($rose(cs_n) |-> fall_cnt_reg >= 5'h0B)
      else $error("deselect before eleven falls");
   a_release_data:
      assert property ($rose(cs_n) |-> ##[1:8] !dout_oe)
      else $error("data not released");
endmodule : acr_props
